/* design/adc_serial_ready_sync.sv */
// Converter serial port: command/data shifting, ready indication, sync reset.
// Assumes the host drives sclk_i and cs_n_i; results arrive on the system clock.
`timescale 1ns/100ps
module adc_serial_ready_sync
#(
  parameter int FIFO_DEPTH = adc_serial_pkg::FIFO_DEPTH
)
(
  // System clock domain
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  // Serial link pins
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   din_i,
  output logic                        dout_o,
  output logic                        dout_oe_o,
  // Synchronisation pin
  input  wire logic                   sync_n_i,
  // Conversion results from the filter
  input  wire adc_serial_pkg::conv_t  conv_i,
  output logic                        conv_ready_o,
  // Filter side controls
  output logic                        filt_rst_o,
  output logic                        mod_rst_o,
  output logic                        cal_rst_o,
  output logic                        rdy_n_o,
  output adc_serial_pkg::reg_wr_t     reg_wr_o
);

  localparam int W = adc_serial_pkg::WORD_W;
  localparam int S = adc_serial_pkg::SEL_W;

  // System clock domain state
  typedef struct packed
  {
    logic                       sync_s1;
    logic                       sync_s2;
    logic                       rd_s1;
    logic                       rd_s2;
    logic                       rd_s3;
    logic                       wr_s1;
    logic                       wr_s2;
    logic                       wr_s3;
    logic                       filt_rst;
    adc_serial_pkg::rdy_state_t rdy_state;
    logic                       rdy_n;
    logic [3:0]                 blank_cnt;
    logic [W-1:0]               hold;
    adc_serial_pkg::reg_wr_t    wr_out;
  } sys_st_t;

  // Serial clock domain state
  typedef struct packed
  {
    logic                                rst_s1;
    logic                                rst_s2;
    logic                                ce_s1;
    logic                                ce_s2;
    logic                                rdy_s1;
    logic                                rdy_s2;
    adc_serial_pkg::lnk_state_t          state;
    logic [adc_serial_pkg::CNT_W-1:0]    bit_cnt;
    logic [adc_serial_pkg::CMD_W-1:0]    cmd_sr;
    logic [S-1:0]                        sel;
    logic [W-1:0]                        in_sr;
    logic [W-1:0]                        out_sr;
    logic [adc_serial_pkg::NREG-1:0][W-1:0] regs;
    logic                                wr_tgl;
    logic [S-1:0]                        wr_addr;
    logic [W-1:0]                        wr_data;
    logic                                rd_tgl;
  } lnk_st_t;

  typedef struct packed
  {
    logic drv;
    logic bit_v;
  } pin_st_t;

  sys_st_t  c_r;
  sys_st_t  c_nxt;
  lnk_st_t  l_r;
  lnk_st_t  l_nxt;
  pin_st_t  p_r;
  logic     frame_r;
  logic         fifo_valid;
  logic         fifo_pop;
  logic [W-1:0] fifo_data;

  // Bits carried by each register on the wire
  function automatic logic [adc_serial_pkg::CNT_W-1:0] reg_bits(input logic [S-1:0] sel);
    reg_bits = (sel == adc_serial_pkg::SEL_STATUS) ? adc_serial_pkg::BITS_SHORT
                                                   : adc_serial_pkg::BITS_LONG;
  endfunction : reg_bits

  // Registers that the host may not write
  function automatic logic read_only(input logic [S-1:0] sel);
    read_only = (sel == adc_serial_pkg::SEL_STATUS) || (sel == adc_serial_pkg::SEL_DATA);
  endfunction : read_only

  conv_fifo
  #(
    .W     (W),
    .DEPTH (FIFO_DEPTH)
  )
  u_fifo
  (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .flush_i     (c_r.filt_rst),
    .in_valid_i  (conv_i.valid),
    .in_ready_o  (conv_ready_o),
    .in_data_i   (conv_i.data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // A result is taken only while the ready pin is high and the filter runs
  assign fifo_pop = (c_r.rdy_state == adc_serial_pkg::RDY_IDLE) && !c_r.filt_rst;

  // System clock domain: sync pin, ready sequencing, write hand-off
  always_comb
  begin
    c_nxt = c_r;
    c_nxt.sync_s1 = sync_n_i;
    c_nxt.sync_s2 = c_r.sync_s1;
    c_nxt.rd_s1 = l_r.rd_tgl;
    c_nxt.rd_s2 = c_r.rd_s1;
    c_nxt.rd_s3 = c_r.rd_s2;
    c_nxt.wr_s1 = l_r.wr_tgl;
    c_nxt.wr_s2 = c_r.wr_s1;
    c_nxt.wr_s3 = c_r.wr_s2;
    c_nxt.wr_out.valid = 1'b0;
    if (c_r.wr_s2 != c_r.wr_s3)
    begin
      // Link words are stable here: they changed on the same serial clock edge as the toggle
      c_nxt.wr_out.valid = 1'b1;
      c_nxt.wr_out.addr  = l_r.wr_addr;
      c_nxt.wr_out.data  = l_r.wr_data;
    end
    c_nxt.filt_rst = ~c_r.sync_s2;
    if (!c_r.sync_s2)
    begin
      c_nxt.rdy_state = adc_serial_pkg::RDY_IDLE;
    end
    else
    begin
      case (c_r.rdy_state)
        adc_serial_pkg::RDY_IDLE:
        begin
          if (fifo_valid && fifo_pop)
          begin
            c_nxt.hold      = fifo_data;
            c_nxt.rdy_state = adc_serial_pkg::RDY_LOW;
          end
        end
        adc_serial_pkg::RDY_LOW:
        begin
          if (c_r.rd_s2 != c_r.rd_s3)
          begin
            c_nxt.rdy_state = adc_serial_pkg::RDY_IDLE;
          end
          else if (fifo_valid)
          begin
            c_nxt.rdy_state = adc_serial_pkg::RDY_BLANK;
            c_nxt.blank_cnt = adc_serial_pkg::BLANK_LOAD;
          end
        end
        adc_serial_pkg::RDY_BLANK:
        begin
          if (c_r.blank_cnt == 4'h0)
          begin
            c_nxt.rdy_state = adc_serial_pkg::RDY_IDLE;
          end
          else
          begin
            c_nxt.blank_cnt = c_r.blank_cnt - 4'h1;
          end
        end
        default:
        begin
          c_nxt.rdy_state = adc_serial_pkg::RDY_IDLE;
        end
      endcase
    end
    c_nxt.rdy_n = (c_nxt.rdy_state != adc_serial_pkg::RDY_LOW);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      c_r           <= '0;
      c_r.sync_s1   <= 1'b1;
      c_r.sync_s2   <= 1'b1;
      c_r.rdy_n     <= 1'b1;
      c_r.rdy_state <= adc_serial_pkg::RDY_IDLE;
      c_r.hold      <= adc_serial_pkg::REG_RESET;
    end
    else if (ce_i)
    begin
      c_r <= c_nxt;
    end
  end

  // Frame marker: cleared at once by chip select high, set by the first clock in frame
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      frame_r <= 1'b0;
    end
    else
    begin
      frame_r <= 1'b1;
    end
  end

  // Serial clock domain: command, write and read shifting
  always_comb
  begin
    logic [adc_serial_pkg::CNT_W-1:0] cnt;
    logic [adc_serial_pkg::CMD_W-1:0] cmd;
    logic [S-1:0]                     sel;
    adc_serial_pkg::lnk_state_t       cur;
    cnt = l_r.bit_cnt;
    cmd = {l_r.cmd_sr[adc_serial_pkg::CMD_W-2:0], din_i};
    sel = cmd[adc_serial_pkg::SEL_LSB +: S];
    cur = l_r.state;
    l_nxt = l_r;
    l_nxt.rst_s1 = reset_i;
    l_nxt.rst_s2 = l_r.rst_s1;
    l_nxt.ce_s1 = ce_i;
    l_nxt.ce_s2 = l_r.ce_s1;
    l_nxt.rdy_s1 = c_r.rdy_n;
    l_nxt.rdy_s2 = l_r.rdy_s1;
    if (!frame_r)
    begin
      // A chip select rise mid-word abandons it
      cur = adc_serial_pkg::LNK_CMD;
      cnt = '0;
    end
    if (l_r.rst_s2)
    begin
      l_nxt.state   = adc_serial_pkg::LNK_CMD;
      l_nxt.bit_cnt = '0;
      l_nxt.regs    = {adc_serial_pkg::NREG{adc_serial_pkg::REG_RESET}};
      l_nxt.wr_tgl  = 1'b0;
      l_nxt.rd_tgl  = 1'b0;
    end
    else if (l_r.ce_s2)
    begin
      case (cur)
        adc_serial_pkg::LNK_CMD:
        begin
          l_nxt.cmd_sr  = cmd;
          l_nxt.bit_cnt = cnt + 1'b1;
          l_nxt.state   = adc_serial_pkg::LNK_CMD;
          if (cnt == adc_serial_pkg::BITS_SHORT - 1'b1)
          begin
            l_nxt.bit_cnt = '0;
            l_nxt.sel     = sel;
            if (!cmd[adc_serial_pkg::CMD_WEN_BIT] && cmd[adc_serial_pkg::CMD_RW_BIT])
            begin
              l_nxt.state = adc_serial_pkg::LNK_RD;
              case (sel)
                adc_serial_pkg::SEL_STATUS:
                begin
                  l_nxt.out_sr = {l_r.rdy_s2, 4'h0, l_r.sel, 16'h0000};
                end
                adc_serial_pkg::SEL_DATA:
                begin
                  l_nxt.out_sr = c_r.hold;
                end
                default:
                begin
                  l_nxt.out_sr = l_r.regs[sel];
                end
              endcase
            end
            else if (!cmd[adc_serial_pkg::CMD_WEN_BIT])
            begin
              l_nxt.state = adc_serial_pkg::LNK_WR;
            end
          end
        end
        adc_serial_pkg::LNK_WR:
        begin
          l_nxt.in_sr   = {l_r.in_sr[W-2:0], din_i};
          l_nxt.bit_cnt = cnt + 1'b1;
          if (cnt == reg_bits(l_r.sel) - 1'b1)
          begin
            l_nxt.state   = adc_serial_pkg::LNK_CMD;
            l_nxt.bit_cnt = '0;
            if (!read_only(l_r.sel))
            begin
              l_nxt.regs[l_r.sel] = l_nxt.in_sr;
              l_nxt.wr_addr       = l_r.sel;
              l_nxt.wr_data       = l_nxt.in_sr;
              l_nxt.wr_tgl        = ~l_r.wr_tgl;
            end
          end
        end
        adc_serial_pkg::LNK_RD:
        begin
          l_nxt.out_sr  = {l_r.out_sr[W-2:0], 1'b0};
          l_nxt.bit_cnt = cnt + 1'b1;
          if (cnt == reg_bits(l_r.sel) - 1'b1)
          begin
            l_nxt.state   = adc_serial_pkg::LNK_CMD;
            l_nxt.bit_cnt = '0;
            if (l_r.sel == adc_serial_pkg::SEL_DATA)
            begin
              l_nxt.rd_tgl = ~l_r.rd_tgl;
            end
          end
        end
        default:
        begin
          l_nxt.state   = adc_serial_pkg::LNK_CMD;
          l_nxt.bit_cnt = '0;
        end
      endcase
    end
  end

  // No sync term here: the link keeps its transfer through a sync pulse
  always_ff @(posedge sclk_i)
  begin
    l_r <= l_nxt;
  end

  // Output bit changes on the falling serial clock edge
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      p_r <= 2'b01;
    end
    else
    begin
      p_r.drv   <= frame_r && (l_r.state == adc_serial_pkg::LNK_RD);
      p_r.bit_v <= l_r.out_sr[W-1];
    end
  end
  // Pin shows shifted data during reads and the ready level otherwise
  assign dout_o    = p_r.drv ? p_r.bit_v : c_r.rdy_n;
  assign dout_oe_o = ~cs_n_i;
  assign filt_rst_o = c_r.filt_rst;
  assign mod_rst_o  = c_r.filt_rst;
  assign cal_rst_o  = c_r.filt_rst;
  assign rdy_n_o    = c_r.rdy_n;
  assign reg_wr_o   = c_r.wr_out;
endmodule : adc_serial_ready_sync

/* design/adc_serial_pkg.sv */
// Shared constants, state encodings and carrier types for the converter serial port.
// Assumes a 40 MHz system clock and a host-driven serial clock on a separate domain.
package adc_serial_pkg;

  // Word and field geometry
  localparam int        WORD_W      = 24;
  localparam int        CMD_W       = 8;
  localparam int        SEL_W       = 3;
  localparam int        NREG        = 8;
  localparam int        CNT_W       = 5;
  localparam int        CMD_WEN_BIT = 7;
  localparam int        CMD_RW_BIT  = 6;
  localparam int        SEL_LSB     = 3;
  localparam logic [SEL_W-1:0] SEL_STATUS = 3'h0;
  localparam logic [SEL_W-1:0] SEL_DATA   = 3'h3;
  localparam logic [CNT_W-1:0] BITS_SHORT = 5'h08;
  localparam logic [CNT_W-1:0] BITS_LONG  = 5'h18;

  // Values after reset
  localparam logic [WORD_W-1:0] REG_RESET = 24'h000000;

  // Timing
  localparam int        CLK_NS      = 25;
  localparam int        BLANK_NS    = 100;
  localparam int        BLANK_CYC   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int        FIFO_DEPTH  = 16;
  localparam logic [3:0] BLANK_LOAD = 4'(BLANK_CYC - 1);

  typedef enum logic [1:0]
  {
    RDY_IDLE  = 2'b00,
    RDY_LOW   = 2'b01,
    RDY_BLANK = 2'b11
  } rdy_state_t;

  typedef enum logic [1:0]
  {
    LNK_CMD = 2'b00,
    LNK_WR  = 2'b01,
    LNK_RD  = 2'b11
  } lnk_state_t;

  // Register write handed to the filter side
  typedef struct packed
  {
    logic              valid;
    logic [SEL_W-1:0]  addr;
    logic [WORD_W-1:0] data;
  } reg_wr_t;

  // Conversion result stream
  typedef struct packed
  {
    logic              valid;
    logic [WORD_W-1:0] data;
  } conv_t;

endpackage : adc_serial_pkg

/* design/conv_fifo.sv */
// Synchronous FIFO for conversion results, parameterised in width and depth.
// Assumes one clock; flush empties it; ce_i low freezes all state.
`timescale 1ns/100ps
module conv_fifo
#(
  parameter int W     = 24,
  parameter int DEPTH = 16
)
(
  // Clock and control
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic         flush_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } fifo_st_t;

  fifo_st_t s_r;
  fifo_st_t s_nxt;
  logic     full;
  logic     empty;

  assign empty       = (s_r.wp == s_r.rp);
  assign full        = (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]) && (s_r.wp[AW] != s_r.rp[AW]);
  assign in_ready_o  = ~full & ~flush_i;
  assign out_valid_o = ~empty & ~flush_i;
  assign out_data_o  = s_r.mem[s_r.rp[AW-1:0]];

  always_comb
  begin
    s_nxt = s_r;
    if (flush_i)
    begin
      s_nxt.rp = s_r.wp;
    end
    else
    begin
      if (in_valid_i && !full)
      begin
        s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
        s_nxt.wp = s_r.wp + 1'b1;
      end
      if (out_ready_i && !empty)
      begin
        s_nxt.rp = s_r.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_r.wp <= '0;
      s_r.rp <= '0;
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

endmodule : conv_fifo

/* tb/adc_serial_asserts.sv */
// Concurrent checks on the system-side pins and the output enable of the converter serial port.
// Assumes it is bound to adc_serial_ready_sync; sync is held low for many cycles at a time.
`timescale 1ns/100ps
module adc_serial_asserts
(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // Watched pins
  input  wire logic                    cs_n_i,
  input  wire logic                    sync_n_i,
  input  wire logic                    dout_oe_o,
  input  wire logic                    conv_ready_o,
  input  wire logic                    filt_rst_o,
  input  wire logic                    mod_rst_o,
  input  wire logic                    cal_rst_o,
  input  wire logic                    rdy_n_o,
  input  wire adc_serial_pkg::reg_wr_t reg_wr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  property p_oe;
    dout_oe_o == !cs_n_i;
  endproperty
  a_oe: assert property (p_oe) else $error("output enable does not follow select");

  property p_sync_on;
    $fell(sync_n_i) |-> ##[1:4] (filt_rst_o && mod_rst_o && cal_rst_o);
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync low did not reset filter");

  property p_sync_off;
    $rose(sync_n_i) |-> ##[1:4] !(filt_rst_o || mod_rst_o || cal_rst_o);
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("filter reset stuck after sync");

  property p_sync_rdy;
    !sync_n_i [*5] |-> rdy_n_o;
  endproperty
  a_sync_rdy: assert property (p_sync_rdy) else $error("ready low during sync");

  property p_sync_fifo;
    !sync_n_i [*5] |-> !conv_ready_o;
  endproperty
  a_sync_fifo: assert property (p_sync_fifo) else $error("results taken during sync");

  property p_rdy_fall;
    $fell(rdy_n_o) |-> $past(sync_n_i, 3);
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready fell while sync low");

  property p_rst_vals;
    $fell(reset_i) |-> rdy_n_o && !reg_wr_o.valid;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");

  property p_wr_pulse;
    reg_wr_o.valid |=> !reg_wr_o.valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe longer than one cycle");

  property p_wr_sel;
    reg_wr_o.valid |-> reg_wr_o.addr != adc_serial_pkg::SEL_STATUS
                       && reg_wr_o.addr != adc_serial_pkg::SEL_DATA;
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write to read-only select");
endmodule : adc_serial_asserts

bind adc_serial_ready_sync adc_serial_asserts adc_serial_asserts_i
(
  .clk_i        (clk_i),
  .reset_i      (reset_i),
  .cs_n_i       (cs_n_i),
  .sync_n_i     (sync_n_i),
  .dout_oe_o    (dout_oe_o),
  .conv_ready_o (conv_ready_o),
  .filt_rst_o   (filt_rst_o),
  .mod_rst_o    (mod_rst_o),
  .cal_rst_o    (cal_rst_o),
  .rdy_n_o      (rdy_n_o),
  .reg_wr_o     (reg_wr_o)
);

/* tb/host_model.sv */
// Behavioural serial master playing the host on the converter link.
// Assumes the clock idles high and the device changes its output on falling edges.
`timescale 1ns/100ps
module host_model
#(
  parameter int HALF_NS = 80
)
(
  // Link pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  // Set to keep chip select low between transfers (three-wire use)
  logic keep_cs;

  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o  = 1'b1;
    keep_cs = 1'b0;
  end

  // Clocks with the device deselected, only around reset
  task automatic idle_clocks(input int n);
    repeat (n)
    begin
      #HALF_NS sclk_o = 1'b0;
      #HALF_NS sclk_o = 1'b1;
    end
  endtask : idle_clocks

  // Command byte then nbits data bits; fewer bits than a word aborts it unless keep_cs holds chip select low
  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [23:0] wd,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h000000;
    cs_n_o = 1'b0;
    #HALF_NS;
    for (int i = 0; i < 8 + nbits; i++)
    begin
      sclk_o = 1'b0;
      din_o  = sh[31];
      sh     = {sh[30:0], 1'b0};
      #HALF_NS sclk_o = 1'b1;
      if (i >= 8)
        rd = {rd[22:0], dout_i};
      #HALF_NS;
    end
    cs_n_o = ~keep_cs;
    din_o  = ~din_o;
    #HALF_NS;
  endtask : xfer
endmodule : host_model

/* tb/tb.sv */
// Self-checking bench for the converter serial port.
// Assumes host_model drives the link; results are pushed on the system clock.
`timescale 1ns/100ps
module tb;
  logic                    clk_i;
  logic                    reset_i;
  logic                    ce_i;
  logic                    sync_n_i;
  adc_serial_pkg::conv_t   conv_i;
  adc_serial_pkg::reg_wr_t reg_wr_o;
  adc_serial_pkg::reg_wr_t wr_last;
  logic                    sclk, cs_n, din, dout_o, dout_oe_o;
  logic                    conv_ready_o, filt_rst_o, mod_rst_o, cal_rst_o, rdy_n_o;
  wire logic               dout_w;
  int                      mismatches, total_checks, wr_cnt;

  assign dout_w = dout_oe_o ? dout_o : 1'bz;

  adc_serial_ready_sync adc_serial_ready_sync_i
  (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .sync_n_i(sync_n_i),
    .conv_i(conv_i), .conv_ready_o(conv_ready_o), .filt_rst_o(filt_rst_o),
    .mod_rst_o(mod_rst_o), .cal_rst_o(cal_rst_o), .rdy_n_o(rdy_n_o), .reg_wr_o(reg_wr_o)
  );

  host_model host_model_i
  (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout_w)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
    if (reg_wr_o.valid === 1'b1)
    begin
      wr_cnt++;
      wr_last = reg_wr_o;
    end

  task automatic print_verdict;
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input logic [23:0] d);
    @(negedge clk_i);
    check(conv_ready_o, 1'b1);
    conv_i = '{1'b1, d};
    @(negedge clk_i);
    conv_i = '0;
    repeat (3) @(negedge clk_i);
  endtask : push

  task automatic rd_data(input logic [23:0] d);
    logic [23:0] rd;
    host_model_i.xfer(8'h58, 24, 24'h000000, rd);
    check(rd, d);
  endtask : rd_data

  task automatic wr(input logic [2:0] s, input logic [23:0] d);
    logic [23:0] rd;
    host_model_i.xfer({2'b00, s, 3'h0}, (s == 3'h0) ? 8 : 24, d, rd);
  endtask : wr

  task automatic chk_wr(input int n, input logic [2:0] s, input logic [23:0] d);
    repeat (8) @(negedge clk_i);
    check(32'(wr_cnt - n), 32'h1);
    check({5'h0, wr_last.addr, wr_last.data}, {5'h0, s, d});
  endtask : chk_wr

  task automatic t_ready_read;
    logic [23:0] rd;
    push(24'ha5c3e1);
    check(rdy_n_o, 1'b0);
    host_model_i.xfer(8'h40, 8, 24'h000000, rd);
    check(rd[7], 1'b0);
    rd_data(24'ha5c3e1);
    repeat (8) @(negedge clk_i);
    check(rdy_n_o, 1'b1);
  endtask : t_ready_read

  task automatic t_writes;
    int n;
    logic [23:0] rd;
    for (int s = 0; s < 8; s++)
    begin
      n = wr_cnt;
      wr(3'(s), 24'h5a3c00 + 24'(s));
      if (s == 0 || s == 3)
      begin
        repeat (8) @(negedge clk_i);
        check(32'(wr_cnt - n), 32'h0);
      end
      else
      begin
        chk_wr(n, 3'(s), 24'h5a3c00 + 24'(s));
        host_model_i.xfer({2'b01, 3'(s), 3'h0}, 24, 24'h000000, rd);
        check(rd, 24'h5a3c00 + 24'(s));
      end
    end
  endtask : t_writes

  task automatic t_abort;
    logic [23:0] rd;
    int n;
    n = wr_cnt;
    host_model_i.xfer(8'h08, 12, 24'hfff000, rd);
    check(dout_oe_o, 1'b0);
    wr(3'h2, 24'h00c0de);
    chk_wr(n, 3'h2, 24'h00c0de);
  endtask : t_abort

  task automatic t_blank;
    int hi;
    hi = 0;
    push(24'h111111);
    check(rdy_n_o, 1'b0);
    fork
      push(24'h222222);
      for (int i = 0; i < 24; i++)
      begin
        @(negedge clk_i);
        if (rdy_n_o === 1'b1)
          hi++;
      end
    join
    check(32'(hi >= adc_serial_pkg::BLANK_CYC), 32'h1);
    check(rdy_n_o, 1'b0);
    rd_data(24'h222222);
  endtask : t_blank

  task automatic t_sync;
    int n;
    push(24'h333333);
    n = wr_cnt;
    fork
      wr(3'h1, 24'h0f0f0f);
      begin
        repeat (60) @(negedge clk_i);
        sync_n_i = 1'b0;
        repeat (8) @(negedge clk_i);
        check(rdy_n_o, 1'b1);
        check({filt_rst_o, mod_rst_o, cal_rst_o}, 3'h7);
        check(conv_ready_o, 1'b0);
        sync_n_i = 1'b1;
      end
    join
    chk_wr(n, 3'h1, 24'h0f0f0f);
    check(filt_rst_o, 1'b0);
  endtask : t_sync

  task automatic t_three_wire;
    logic [23:0] rd;
    int n;
    n = wr_cnt;
    host_model_i.keep_cs = 1'b1;
    wr(3'h5, 24'h0a0b0c);
    chk_wr(n, 3'h5, 24'h0a0b0c);
    push(24'h3c5a69);
    check(dout_oe_o, 1'b1);
    check(dout_w, 1'b0);
    rd_data(24'h3c5a69);
    host_model_i.keep_cs = 1'b0;
    host_model_i.xfer(8'h40, 8, 24'h000000, rd);
    check(rd[7], 1'b1);
    check(dout_oe_o, 1'b0);
  endtask : t_three_wire

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end

  initial
  begin
    reset_i  = 1'b1;
    ce_i     = 1'b1;
    sync_n_i = 1'b1;
    conv_i   = '0;
    fork
      host_model_i.idle_clocks(3);
      repeat (5) @(negedge clk_i);
    join
    @(negedge clk_i);
    reset_i = 1'b0;
    host_model_i.idle_clocks(3);
    t_ready_read();
    t_writes();
    t_abort();
    t_blank();
    t_sync();
    t_three_wire();
    print_verdict();
  end
endmodule : tb
